// ===== rtl/i2c_promisc_defs.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  two-wire slave address capture and promiscuous-address block.
  Assumes inclusion by bare name from the rtl/ folder.
*/
`ifndef I2C_PROMISC_DEFS_SVH
`define I2C_PROMISC_DEFS_SVH

`define OFF_WAKE_STATUS 12'h060
`define OFF_WAKE_ENABLE 12'h064
`define OFF_CAPTURED_ADDR 12'h06C
`define OFF_PROMISC_STATUS 12'h070
`define OFF_PROMISC_IRQ_EN 12'h074
`define OFF_PROMISC_ACK_CTRL 12'h078
`define OFF_SLAVE_CTRL 12'h07C

`define BIT_START_DET 0
`define BIT_PROMISC_ADDR 0
`define BIT_CTRL_ENABLE 0
`define BIT_CTRL_PROMISC 1

`define RST_WAKE_ENABLE 1'b0
`define RST_CAPTURED_ADDR 8'h00
`define RST_PROMISC_ACK 1'b0
`define RST_CTRL 2'h0

`define SYS_CLK_HZ 10000000
`define ACK_HOLD_NS 300
`define ACK_HOLD_CYC ((`ACK_HOLD_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ===== rtl/i2c_promisc_pkg.sv
/*
  Types shared by the two-wire slave address capture block.
  Assumes the defs header supplies all numeric constants.
*/
package i2c_promisc_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } bus_events_type;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_addr = 5'b00010,
    st_stretch = 5'b00100,
    st_ack = 5'b01000,
    st_skip = 5'b10000
  } slave_state_type;

endpackage

// ===== rtl/i2c_line_watch.sv
/*
  Synchronises the two-wire bus lines and derives START, STOP and SCL edges.
  Assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module i2c_line_watch
  import i2c_promisc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bus_lines_type pins,
  output bus_lines_type lines,
  output bus_events_type events
);

  bus_lines_type meta;
  bus_lines_type prev;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 2'h3;
      lines <= 2'h3;
      prev <= 2'h3;
    end
    else if (clk_en)
    begin
      meta <= pins;
      lines <= meta;
      prev <= lines;
    end
  end

  // START/STOP are SDA edges while SCL stays high
  assign events.start = prev.scl && lines.scl && prev.sda && !lines.sda;
  assign events.stop = prev.scl && lines.scl && !prev.sda && lines.sda;
  assign events.scl_rise = !prev.scl && lines.scl;
  assign events.scl_fall = prev.scl && !lines.scl;

endmodule

// ===== rtl/i2c_slave_promisc.sv
/*
  Two-wire slave first-byte capture, promiscuous address handling with
  ninth-clock stretch, START wake detection and an APB register slave.
  Assumes an APB master on sys_clk and open-drain SCL/SDA pins outside.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "i2c_promisc_defs.svh"
module i2c_slave_promisc
  import i2c_promisc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wake_irq,
  output logic irq
);

  bus_lines_type lines;
  bus_events_type ev;
  slave_state_type state;
  slave_state_type next_state;

  logic ctrl_enable;
  logic ctrl_promisc;
  logic wake_enable;
  logic start_status;
  logic promisc_status;
  logic promisc_irq_en;
  logic ack_ctrl;
  logic [7:0] captured_addr;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic ack_bit;
  logic sda_low;
  logic scl_low;
  logic [3:0] setup_cnt;
  bus_lines_type pin_lines;

  assign pin_lines = '{scl: scl_in, sda: sda_in};

  i2c_line_watch u_watch (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pins(pin_lines),
    .lines(lines),
    .events(ev)
  );

  // APB decode
  wire wr_cyc = psel && penable && pwrite && clk_en;
  wire sel_wake_st = paddr == `OFF_WAKE_STATUS;
  wire sel_wake_en = paddr == `OFF_WAKE_ENABLE;
  wire sel_addr = paddr == `OFF_CAPTURED_ADDR;
  wire sel_pst = paddr == `OFF_PROMISC_STATUS;
  wire sel_pen = paddr == `OFF_PROMISC_IRQ_EN;
  wire sel_ack = paddr == `OFF_PROMISC_ACK_CTRL;
  wire sel_ctrl = paddr == `OFF_SLAVE_CTRL;
  wire mapped = sel_wake_st | sel_wake_en | sel_addr | sel_pst | sel_pen | sel_ack | sel_ctrl;
  wire wr_wake_st = wr_cyc && sel_wake_st;
  wire wr_pst = wr_cyc && sel_pst;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  wire [31:0] rd_mux =
    sel_wake_st ? {31'h0, start_status} :
    sel_wake_en ? {31'h0, wake_enable} :
    sel_addr ? {24'h0, captured_addr} :
    sel_pst ? {31'h0, promisc_status} :
    sel_pen ? {31'h0, promisc_irq_en} :
    sel_ack ? {31'h0, ack_ctrl} :
    sel_ctrl ? {30'h0, ctrl_promisc, ctrl_enable} : 32'h0;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (clk_en && psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_enable <= `RST_WAKE_ENABLE;
      promisc_irq_en <= 1'b0;
      ack_ctrl <= `RST_PROMISC_ACK;
      {ctrl_promisc, ctrl_enable} <= `RST_CTRL;
    end
    else if (wr_cyc)
    begin
      if (sel_wake_en)
        wake_enable <= pwdata[`BIT_START_DET];
      if (sel_pen)
        promisc_irq_en <= pwdata[`BIT_PROMISC_ADDR];
      if (sel_ack)
        ack_ctrl <= pwdata[`BIT_PROMISC_ADDR];
      if (sel_ctrl)
        {ctrl_promisc, ctrl_enable} <= {pwdata[`BIT_CTRL_PROMISC], pwdata[`BIT_CTRL_ENABLE]};
    end
  end

  // Set wins over a same-cycle write-one clear
  wire set_start = ev.start && ctrl_enable;
  wire clr_start = wr_wake_st && pwdata[`BIT_START_DET];
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      start_status <= 1'b0;
    else if (clk_en)
      start_status <= set_start || (start_status && !clr_start);
  end

  assign wake_irq = start_status && wake_enable;
  assign irq = promisc_status && promisc_irq_en;

  // Byte completes on the falling SCL edge after the eighth rising edge
  wire byte_done = state == st_addr && ev.scl_fall && bit_cnt == 4'h8;
  wire set_promisc = byte_done && ctrl_promisc;
  wire clr_promisc = wr_pst && pwdata[`BIT_PROMISC_ADDR];
  wire release_now = state == st_stretch && !promisc_status;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      promisc_status <= 1'b0;
    else if (clk_en)
      promisc_status <= set_promisc || (promisc_status && !clr_promisc);
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:
        next_state = state;
      st_addr:
        if (byte_done)
          next_state = ctrl_promisc ? st_stretch : st_skip;
      st_stretch:
        if (release_now)
          next_state = st_ack;
      st_ack:
        if (ev.scl_fall)
          next_state = st_skip;
      st_skip:
        next_state = state;
      default:
        next_state = st_idle;
    endcase
    if (ev.start && ctrl_enable)
      next_state = st_addr;
    else if (ev.stop || !ctrl_enable)
      next_state = st_idle;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (ev.start)
        bit_cnt <= 4'h0;
      else if (state == st_addr && ev.scl_rise)
      begin
        bit_cnt <= bit_cnt + 4'h1;
        shift <= {shift[6:0], lines.sda};
      end
    end
  end

  // Capture on the eighth rising edge, before the ninth clock
  wire cap_now = state == st_addr && ev.scl_rise && bit_cnt == 4'h7;
  wire [7:0] next_addr = {shift[6:0], lines.sda};
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      captured_addr <= `RST_CAPTURED_ADDR;
    else if (clk_en && cap_now)
      captured_addr <= next_addr;
    else if (wr_cyc && sel_addr)
      captured_addr <= pwdata[7:0];
  end

  // Ack decision taken when stretching ends so software can set it first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ack_bit <= 1'b0;
    else if (clk_en && release_now)
      ack_bit <= ack_ctrl;
  end

  // SDA must settle before SCL is let go, otherwise a master could see a
  // falling SDA with SCL high and take it for a START
  wire setup_done = setup_cnt == 4'(`ACK_HOLD_CYC);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      setup_cnt <= 4'h0;
    else if (clk_en)
    begin
      if (state != st_ack)
        setup_cnt <= 4'h0;
      else if (!setup_done)
        setup_cnt <= setup_cnt + 4'h1;
    end
  end

  // Non-promiscuous ACK handling belongs to the wider controller
  assign sda_low = state == st_ack && ack_bit;
  assign scl_low = state == st_stretch || (state == st_ack && !setup_done);

  // Open drain: only ever drive low, enable is active low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = !sda_low;
  assign scl_oe_n = !scl_low;

  property p_stretch_holds;
    @(posedge sys_clk) disable iff (rst)
    promisc_status && clk_en |=> !scl_oe_n || !promisc_status;
  endproperty
  a_stretch_holds: assert property (p_stretch_holds) else $error("SCL not stretched");

  property p_promisc_only;
    @(posedge sys_clk) disable iff (rst)
    $rose(promisc_status) |-> $past(ctrl_promisc) && $past(state) == st_addr;
  endproperty
  a_promisc_only: assert property (p_promisc_only) else $error("Bad promisc set");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (rst)
    irq |-> promisc_irq_en && promisc_status;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Irq not gated");

  property p_wake_gate;
    @(posedge sys_clk) disable iff (rst)
    !wake_enable |-> !wake_irq;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("Wake irq ungated");

  property p_start_set;
    @(posedge sys_clk) disable iff (rst)
    clk_en && ev.start && ctrl_enable |=> start_status;
  endproperty
  a_start_set: assert property (p_start_set) else $error("Start not flagged");

  property p_capture;
    @(posedge sys_clk) disable iff (rst)
    clk_en && cap_now |=> captured_addr == $past(next_addr);
  endproperty
  a_capture: assert property (p_capture) else $error("Address not captured");

  sequence s_release;
    clk_en && release_now ##1 state == st_ack;
  endsequence
  property p_ack_sample;
    @(posedge sys_clk) disable iff (rst)
    s_release |-> ack_bit == $past(ack_ctrl, 1) && sda_oe_n == !ack_bit;
  endproperty
  a_ack_sample: assert property (p_ack_sample) else $error("Ack not sampled");

  property p_nak;
    @(posedge sys_clk) disable iff (rst)
    state == st_ack && !ack_bit |-> sda_oe_n;
  endproperty
  a_nak: assert property (p_nak) else $error("NAK drove SDA");

  property p_stretch_enter;
    @(posedge sys_clk) disable iff (rst)
    clk_en && ctrl_enable && set_promisc |=> state == st_stretch && !scl_oe_n;
  endproperty
  a_stretch_enter: assert property (p_stretch_enter) else $error("Stretch not entered");

  property p_start_clear;
    @(posedge sys_clk) disable iff (rst)
    clr_start && !set_start |=> !start_status;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("Start flag not cleared");

  property p_start_keep;
    @(posedge sys_clk) disable iff (rst)
    start_status && !clr_start |=> start_status;
  endproperty
  a_start_keep: assert property (p_start_keep) else $error("Start flag lost");

  property p_promisc_keep;
    @(posedge sys_clk) disable iff (rst)
    promisc_status && !clr_promisc |=> promisc_status;
  endproperty
  a_promisc_keep: assert property (p_promisc_keep) else $error("Promisc flag lost");

  sequence s_cleared;
    promisc_status && clr_promisc && !set_promisc;
  endsequence
  property p_release;
    @(posedge sys_clk) disable iff (rst)
    s_cleared ##1 (clk_en && ctrl_enable && state == st_stretch) |=> state == st_ack;
  endproperty
  a_release: assert property (p_release) else $error("Stretch not released");

  property p_addr_start;
    @(posedge sys_clk) disable iff (rst)
    clk_en && ev.start && ctrl_enable |=> state == st_addr && bit_cnt == 4'h0;
  endproperty
  a_addr_start: assert property (p_addr_start) else $error("Address phase not begun");

  property p_ack_setup;
    @(posedge sys_clk) disable iff (rst)
    $rose(scl_oe_n) && state == st_ack |-> $past(sda_oe_n) == !ack_bit;
  endproperty
  a_ack_setup: assert property (p_ack_setup) else $error("SDA late for ninth clock");

  property p_ack_drop;
    @(posedge sys_clk) disable iff (rst)
    state == st_ack && clk_en && ev.scl_fall |=> sda_oe_n;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("SDA held after ninth clock");

endmodule

// ===== test/i2c_master_model.sv
/*
  Behavioural two-wire bus master driving open-drain pulls on SCL and SDA.
  Assumes the bench resolves each wired line with a pull-up and calls the
  tasks just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module i2c_master_model
(
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic start_cond();
    sda_pull <= 1'b1;
    hold(10);
    scl_pull <= 1'b1;
    hold(10);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull <= ~b[i];
      hold(5);
      scl_pull <= 1'b0;
      hold(10);
      scl_pull <= 1'b1;
      hold(5);
    end
    // Let SDA go while SCL is still low so the release is never a STOP
    sda_pull <= 1'b0;
    hold(5);
    // Let SCL go; a promiscuous slave has taken over the stretch by now
    scl_pull <= 1'b0;
  endtask
  // Ninth clock high phase only starts once the slave lets go of SCL
  task automatic ninth(output logic ack);
    while (scl !== 1'b1)
      hold(1);
    hold(5);
    ack = ~sda;
    scl_pull <= 1'b1;
    hold(5);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    hold(5);
    scl_pull <= 1'b0;
    hold(5);
    sda_pull <= 1'b0;
    hold(10);
  endtask
endmodule

// ===== test/tb_top.sv
/*
  Self-checking bench: APB register tasks plus a two-wire master model.
  Assumes the slave block, its package and its defs header under rtl/.
*/
`timescale 1ns/1ps
`include "i2c_promisc_defs.svh"
module tb_top
  import i2c_promisc_pkg::*;
;
  logic sys_clk, rst, clk_en, psel, penable, pwrite, err, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, wake_irq, irq;
  logic scl_pull, sda_pull;
  wire scl_line = ~scl_pull & (scl_oe_n | scl_out);
  wire sda_line = ~sda_pull & (sda_oe_n | sda_out);
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [11:0] offs [6] = '{`OFF_WAKE_STATUS, `OFF_WAKE_ENABLE, `OFF_CAPTURED_ADDR,
    `OFF_PROMISC_STATUS, `OFF_PROMISC_IRQ_EN, `OFF_PROMISC_ACK_CTRL};
  logic [31:0] wexp [6] = '{32'h0, 32'h1, 32'hFF, 32'h0, 32'h1, 32'h1};
  i2c_slave_promisc DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .wake_irq(wake_irq), .irq(irq));
  i2c_master_model m (.sys_clk(sys_clk), .scl(scl_line), .sda(sda_line),
    .scl_pull(scl_pull), .sda_pull(sda_pull));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so back-to-back calls never assign psel twice at once
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    {rst, clk_en, psel, penable, pwrite, paddr, pwdata} = {3'b110, 46'h0};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    m.hold(4);
    foreach (offs[i])
    begin
      xfer(1'b0, offs[i], 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, offs[i], 32'hFFFFFFFF);
      xfer(1'b0, offs[i], 32'h0);
      check(rd, wexp[i]);
    end
    xfer(1'b0, 12'h100, 32'h0);
    check({rd[30:0], err}, 32'h1);
    xfer(1'b1, `OFF_WAKE_ENABLE, 32'h0);
    xfer(1'b1, `OFF_PROMISC_IRQ_EN, 32'h0);
    xfer(1'b1, `OFF_SLAVE_CTRL, 32'h1);
    m.start_cond();
    m.send_byte(8'h5A);
    m.ninth(ack);
    m.stop_cond();
    check({31'h0, ack}, 32'h0);
    xfer(1'b0, `OFF_CAPTURED_ADDR, 32'h0);
    check(rd, 32'h5A);
    xfer(1'b0, `OFF_PROMISC_STATUS, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, `OFF_WAKE_STATUS, 32'h0);
    check(rd, 32'h1);
    check({31'h0, wake_irq}, 32'h0);
    xfer(1'b1, `OFF_WAKE_ENABLE, 32'h1);
    check({31'h0, wake_irq}, 32'h1);
    xfer(1'b1, `OFF_WAKE_STATUS, 32'h0);
    xfer(1'b0, `OFF_WAKE_STATUS, 32'h0);
    check(rd, 32'h1);
    xfer(1'b1, `OFF_WAKE_STATUS, 32'h1);
    xfer(1'b0, `OFF_WAKE_STATUS, 32'h0);
    check({rd[30:0], wake_irq}, 32'h0);
    // A write while the clock enable is low must be ignored
    clk_en <= 1'b0;
    xfer(1'b1, `OFF_WAKE_ENABLE, 32'h0);
    clk_en <= 1'b1;
    xfer(1'b0, `OFF_WAKE_ENABLE, 32'h0);
    check(rd, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, `OFF_SLAVE_CTRL, 32'h3);
      xfer(1'b1, `OFF_PROMISC_ACK_CTRL, 32'(1 - k));
      xfer(1'b1, `OFF_PROMISC_IRQ_EN, 32'h0);
      m.start_cond();
      m.send_byte(8'hA4 | 8'(k));
      m.hold(30);
      check({31'h0, scl_line}, 32'h0);
      xfer(1'b0, `OFF_PROMISC_STATUS, 32'h0);
      check(rd, 32'h1);
      xfer(1'b0, `OFF_CAPTURED_ADDR, 32'h0);
      check(rd, 32'hA4 | 32'(k));
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, `OFF_PROMISC_IRQ_EN, 32'h1);
      check({31'h0, irq}, 32'h1);
      // Decision changed during the stretch must still count
      xfer(1'b1, `OFF_PROMISC_ACK_CTRL, 32'(k));
      check({31'h0, scl_line}, 32'h0);
      xfer(1'b1, `OFF_PROMISC_STATUS, 32'h1);
      check({31'h0, irq}, 32'h0);
      m.ninth(ack);
      check({31'h0, ack}, 32'(k));
      m.stop_cond();
    end
    final_report();
  end
endmodule
